// [include/uecs_pkg.sv]
// Constants, register layout and carriers for the UART enhanced control and status block.
// Assumes an APB master on pclk and a UART core that supplies FIFO, shifter and serial events.
// Notes on behaviour
// - Status RTS/DTR bits invert pins outside loopback
// - Special char flag sets, clears on status read
// - Report raw FIFO-size pin and FIFO depth while FIFOs enabled
// - Transmitter idle when FIFO and shifter empty
// - Tx level over-reports, rx level under-reports
// - Receiver disable stores nothing, keeps flow control
// - Transmitter disable holds data, flow chars allowed
// - DSR inactive high blocks transmission when enabled
// - DTR field picks modem, flow, RS485 enables
// - Clock select bits 4/5 put clock on DTR
// - Enhanced enable picks programmable or legacy thresholds
// - Read remap for indexed and extended status reads
// - Tx interrupt when level below tx trigger
// - Zero tx trigger means fully idle transmitter
// - Rx interrupt when level reaches rx trigger
// - Legacy XOFF at upper, XON below lower
// - One XOFF at high, one XON below low
// - RTS/DTR deassert at high, reassert below low
// - Four read-only identification bytes at 08-0B
// - Clock select cleared by hardware reset only
// - Two-bit receiver clock source select
// - Receiver 1x bit selects isochronous sampling
// - Transmitter clock source and 1x select
package uecs_pkg;
    // Indexed register offsets, byte address is four times the index.
    localparam logic [4:0] IDX_ACR  = 5'h00;
    localparam logic [4:0] IDX_CKS  = 5'h03;
    localparam logic [4:0] IDX_TTL  = 5'h04;
    localparam logic [4:0] IDX_RTL  = 5'h05;
    localparam logic [4:0] IDX_FCL  = 5'h06;
    localparam logic [4:0] IDX_FCH  = 5'h07;
    localparam logic [4:0] IDX_ID1  = 5'h08;
    localparam logic [4:0] IDX_ID2  = 5'h09;
    localparam logic [4:0] IDX_ID3  = 5'h0A;
    localparam logic [4:0] IDX_REV  = 5'h0B;
    // Own registers in a second window: word indices 0x10 upward.
    localparam logic [4:0] IDX_LSR  = 5'h10;
    localparam logic [4:0] IDX_IER  = 5'h11;
    localparam logic [4:0] IDX_LCR  = 5'h12;
    localparam logic [4:0] IDX_MCR  = 5'h13;
    localparam logic [4:0] IDX_FCR  = 5'h14;
    localparam logic [4:0] IDX_EFR  = 5'h15;
    localparam logic [4:0] IDX_SEL  = 5'h16;
    localparam logic [4:0] IDX_ASR  = 5'h17;
    localparam logic [4:0] IDX_CTL  = 5'h18;
    // Arbitrary neutral identification values.
    localparam logic [7:0] ID1_VAL  = 8'hA1;
    localparam logic [7:0] ID2_VAL  = 8'hA2;
    localparam logic [7:0] ID3_VAL  = 8'hA3;
    localparam logic [7:0] REV_VAL  = 8'h01;
    // Additional control bits.
    localparam int ACR_RXDIS = 0;
    localparam int ACR_TXDIS = 1;
    localparam int ACR_DSRFC = 2;
    localparam int ACR_DTR_LO = 3;
    localparam int ACR_ENH   = 5;
    localparam int ACR_IDXRD = 6;
    localparam int ACR_ASREN = 7;
    // Other bit positions.
    localparam int IER_RX    = 0;
    localparam int IER_TX    = 1;
    localparam int MCR_RTS   = 1;
    localparam int MCR_DTR   = 0;
    localparam int MCR_LOOP  = 4;
    localparam int FCR_EN    = 0;
    localparam int EFR_RTS   = 6;
    localparam int EFR_CTS   = 7;
    localparam int ASR_TXOFF = 0;
    localparam int ASR_SPEC  = 4;
    localparam int CTL_SWRST = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] FULL_DEPTH = 8'h80;
    localparam logic [7:0] SMALL_DEPTH = 8'h10;
    localparam logic [1:0] DTR_NORMAL = 2'b00;
    localparam logic [1:0] DTR_FLOW   = 2'b01;
    localparam logic [1:0] DTR_485LO  = 2'b10;
    localparam logic [1:0] DTR_485HI  = 2'b11;
    localparam logic [1:0] RXC_PIN    = 2'b00;
    localparam logic [1:0] RXC_DSR    = 2'b01;
    localparam logic [1:0] RXC_BAUD   = 2'b10;
    localparam logic [1:0] RXC_TX     = 2'b11;
    // Legacy upper thresholds per FIFO_CTRL_REG[7:6] code, one fixed lower threshold, transmit levels per [5:4].
    localparam logic [7:0] LEG_HI0 = 8'h10;
    localparam logic [7:0] LEG_HI1 = 8'h20;
    localparam logic [7:0] LEG_HI2 = 8'h70;
    localparam logic [7:0] LEG_HI3 = 8'h78;
    localparam logic [7:0] LEG_LO  = 8'h01;
    localparam logic [7:0] LEG_TX0 = 8'h10;
    localparam logic [7:0] LEG_TX1 = 8'h20;
    localparam logic [7:0] LEG_TX2 = 8'h40;
    localparam logic [7:0] LEG_TX3 = 8'h70;

    typedef enum logic [1:0] {FC_RUN, FC_SEND_XOFF, FC_STOPPED, FC_SEND_XON} uecs_fc_t;

    // Status from the UART core.
    typedef struct packed {
        logic       tx_fifo_empty;
        logic       tx_shift_empty;
        logic       serial_output_idle;
        logic       tx_push;
        logic       tx_pop;
        logic       rx_frame_done;
        logic       rx_is_special;
        logic       rx_is_flowchar;
        logic       rx_pop;
        logic       rx_busy;
        logic       tx_busy;
        logic [7:0] line_stat_reg;
    } uecs_core_t;

    // Controls to the UART core.
    typedef struct packed {
        logic       rx_store_en;
        logic       rx_special_en;
        logic       tx_data_en;
        logic       send_xoff;
        logic       send_xon;
        logic [1:0] rx_clk_src;
        logic       rx_iso;
        logic       tx_clk_ext;
        logic       tx_iso;
        logic       irq_tx;
        logic       irq_rx;
    } uecs_ctrl_t;
endpackage

// [design/uecs_top.sv]
// Enhanced control and status logic for one UART channel, with an APB register slave.
// Assumes the UART core drives core_i in pclk and acts on ctrl_o the same cycle.
`timescale 1ns/1ps
`default_nettype none
module uecs_top #(
    parameter int DEPTH = 128
) (
    // APB slave
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    // UART core
    input  wire uecs_pkg::uecs_core_t core_i,
    output uecs_pkg::uecs_ctrl_t      ctrl_o,
    // Pins
    input  wire logic                 fifo_size_pin,
    input  wire logic                 dsr_n,
    input  wire logic                 tx_clk_1x,
    input  wire logic                 baud_gen_output,
    output logic                      rts_n,
    output logic                      dtr_n
);
    import uecs_pkg::*;

    // Only the two supported FIFO depths have a size code in the status byte.
    if (DEPTH != 128 && DEPTH != 16)
    begin : g_depth_check
        $error("DEPTH must be 16 or 128");
    end

    logic [7:0] acr_ff, cks_ff, ttl_ff, rtl_ff, fcl_ff, fch_ff;
    logic [7:0] ier_ff, lcr_ff, mcr_ff, fcr_ff, efr_ff;
    logic [4:0] sel_ff;
    logic       spec_ff, txoff_ff, swrst_ff;
    logic [7:0] rx_cnt_ff, tx_cnt_ff;
    logic       rxdis_ff, txdis_ff;
    uecs_fc_t   fc_ff;
    logic       oob_stop_ff;

    logic       wr_en, rd_en;
    logic [4:0] widx;
    logic [7:0] wb;
    logic [7:0] hi_th, lo_th, tx_th, rx_th, asr_v, rd_val;
    logic       tx_idle, fifo_big, flow_on;

    assign wr_en = psel & penable & pwrite & clk_en;
    assign rd_en = psel & penable & ~pwrite & clk_en;
    assign widx  = paddr[6:2];
    assign wb    = pwdata[7:0];
    assign pready = 1'b1;

    // Legacy thresholds come from the FIFO control trigger code.
    function automatic logic [7:0] leg_hi(input logic [1:0] c);
        case (c)
            2'd0: leg_hi = LEG_HI0;
            2'd1: leg_hi = LEG_HI1;
            2'd2: leg_hi = LEG_HI2;
            default: leg_hi = LEG_HI3;
        endcase
    endfunction

    function automatic logic [7:0] leg_tx(input logic [1:0] c);
        case (c)
            2'd0: leg_tx = LEG_TX0;
            2'd1: leg_tx = LEG_TX1;
            2'd2: leg_tx = LEG_TX2;
            default: leg_tx = LEG_TX3;
        endcase
    endfunction

    // The status byte is reached at its own index or through the remapped enable location.
    function automatic logic hits_status(input logic [4:0] idx, input logic remap);
        hits_status = idx == IDX_ASR || (idx == IDX_IER && remap);
    endfunction

    always_comb
    begin
        if (acr_ff[ACR_ENH])
        begin
            hi_th = fch_ff;
            lo_th = fcl_ff;
            tx_th = {1'b0, ttl_ff[6:0]};
            rx_th = {1'b0, rtl_ff[6:0]};
        end
        else
        begin
            hi_th = leg_hi(fcr_ff[7:6]);
            lo_th = LEG_LO;
            tx_th = leg_tx(fcr_ff[5:4]);
            rx_th = leg_hi(fcr_ff[7:6]);
        end
    end

    // Control registers; clock select survives the channel software reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cks_ff <= RESET_BYTE;
        end
        else if (wr_en && widx == IDX_CKS)
        begin
            cks_ff <= wb;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acr_ff <= RESET_BYTE; ttl_ff <= RESET_BYTE; rtl_ff <= RESET_BYTE;
            fcl_ff <= RESET_BYTE; fch_ff <= RESET_BYTE; ier_ff <= RESET_BYTE;
            lcr_ff <= RESET_BYTE; mcr_ff <= RESET_BYTE; fcr_ff <= RESET_BYTE;
            efr_ff <= RESET_BYTE; sel_ff <= 5'h00;
        end
        else if (swrst_ff && clk_en)
        begin
            acr_ff <= RESET_BYTE; ttl_ff <= RESET_BYTE; rtl_ff <= RESET_BYTE;
            fcl_ff <= RESET_BYTE; fch_ff <= RESET_BYTE; ier_ff <= RESET_BYTE;
            lcr_ff <= RESET_BYTE; mcr_ff <= RESET_BYTE; fcr_ff <= RESET_BYTE;
            efr_ff <= RESET_BYTE; sel_ff <= 5'h00;
        end
        else if (wr_en)
        begin
            // Writes always reach the original register whatever the read remap.
            case (widx)
                IDX_ACR: acr_ff <= wb;
                IDX_TTL: ttl_ff <= wb;
                IDX_RTL: rtl_ff <= wb;
                IDX_FCL: fcl_ff <= wb;
                IDX_FCH: fch_ff <= wb;
                IDX_IER: ier_ff <= wb;
                IDX_LCR: lcr_ff <= wb;
                IDX_MCR: mcr_ff <= wb;
                IDX_FCR: fcr_ff <= wb;
                IDX_EFR: efr_ff <= wb;
                IDX_SEL: sel_ff <= wb[4:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            swrst_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            swrst_ff <= wr_en && widx == IDX_CTL && wb[CTL_SWRST];
        end
    end

    // Disable bits take effect only between frames.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rxdis_ff <= 1'b0;
            txdis_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!core_i.rx_busy)
            begin
                rxdis_ff <= acr_ff[ACR_RXDIS];
            end
            if (!core_i.tx_busy)
            begin
                txdis_ff <= acr_ff[ACR_TXDIS];
            end
        end
    end

    // Live counts: transmit reported as pushed-not-yet-sent, so never below truth.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_cnt_ff <= RESET_BYTE;
            tx_cnt_ff <= RESET_BYTE;
        end
        else if (clk_en)
        begin
            rx_cnt_ff <= rx_cnt_ff
                + 8'((core_i.rx_frame_done && !rxdis_ff) ? 1 : 0)
                - 8'(core_i.rx_pop ? 1 : 0);
            // An empty FIFO resyncs the count, yet a push in that same cycle still counts.
            tx_cnt_ff <= (core_i.tx_fifo_empty && !core_i.tx_push) ? RESET_BYTE
                : tx_cnt_ff + 8'(core_i.tx_push ? 1 : 0) - 8'(core_i.tx_pop ? 1 : 0);
        end
    end

    // Special character flag: a new detection wins over the clearing read.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            spec_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (core_i.rx_frame_done && core_i.rx_is_special && !rxdis_ff)
            begin
                spec_ff <= 1'b1;
            end
            else if (rd_en && hits_status(widx, acr_ff[ACR_ASREN]))
            begin
                spec_ff <= 1'b0;
            end
        end
    end

    assign flow_on = efr_ff[3:0] != 4'h0;

    // In-band flow control: exactly one XOFF per crossing of the high level.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fc_ff <= FC_RUN;
        end
        else if (clk_en)
        begin
            case (fc_ff)
                FC_RUN:       if (flow_on && rx_cnt_ff >= hi_th) fc_ff <= FC_SEND_XOFF;
                FC_SEND_XOFF: fc_ff <= FC_STOPPED;
                FC_STOPPED:   if (rx_cnt_ff < lo_th) fc_ff <= FC_SEND_XON;
                FC_SEND_XON:  fc_ff <= FC_RUN;
                default:      fc_ff <= FC_RUN;
            endcase
        end
    end

    // Out-of-band stop state for RTS and DTR.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oob_stop_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rx_cnt_ff >= hi_th)
            begin
                oob_stop_ff <= 1'b1;
            end
            else if (rx_cnt_ff < lo_th)
            begin
                oob_stop_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            txoff_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            txoff_ff <= 1'b0;
        end
    end

    assign tx_idle  = core_i.tx_fifo_empty && core_i.tx_shift_empty;
    assign fifo_big = DEPTH == 128;

    // Pin outputs; RS485 enable waits for the line to settle at mark.
    always_comb
    begin
        rts_n = ~mcr_ff[MCR_RTS] | (efr_ff[EFR_RTS] & oob_stop_ff);
        if (cks_ff[4])
        begin
            dtr_n = tx_clk_1x;
        end
        else if (cks_ff[5])
        begin
            dtr_n = baud_gen_output;
        end
        else
        begin
            case (acr_ff[4:3])
                DTR_NORMAL: dtr_n = ~mcr_ff[MCR_DTR];
                DTR_FLOW:   dtr_n = oob_stop_ff;
                DTR_485LO:  dtr_n = tx_idle & core_i.serial_output_idle;
                default:    dtr_n = ~(tx_idle & core_i.serial_output_idle);
            endcase
        end
    end

    always_comb
    begin
        asr_v = {tx_idle,
                 fifo_big & fcr_ff[FCR_EN],
                 fifo_size_pin,
                 spec_ff,
                 mcr_ff[MCR_LOOP] ? oob_stop_ff : ~dtr_n,
                 mcr_ff[MCR_LOOP] ? oob_stop_ff : ~rts_n,
                 fc_ff == FC_STOPPED,
                 txoff_ff};
        case (widx)
            IDX_LSR: rd_val = acr_ff[ACR_IDXRD] ? 8'h00 : core_i.line_stat_reg;
            IDX_IER: rd_val = acr_ff[ACR_ASREN] ? asr_v : ier_ff;
            IDX_LCR: rd_val = acr_ff[ACR_ASREN] ? tx_cnt_ff : lcr_ff;
            IDX_MCR: rd_val = acr_ff[ACR_ASREN] ? rx_cnt_ff : mcr_ff;
            IDX_FCR: rd_val = fcr_ff;
            IDX_EFR: rd_val = efr_ff;
            IDX_SEL: rd_val = {3'b000, sel_ff};
            IDX_ASR: rd_val = asr_v;
            IDX_ACR: rd_val = acr_ff;
            IDX_CKS: rd_val = cks_ff;
            IDX_TTL: rd_val = ttl_ff;
            IDX_RTL: rd_val = rtl_ff;
            IDX_FCL: rd_val = fcl_ff;
            IDX_FCH: rd_val = fch_ff;
            IDX_ID1: rd_val = ID1_VAL;
            IDX_ID2: rd_val = ID2_VAL;
            IDX_ID3: rd_val = ID3_VAL;
            IDX_REV: rd_val = REV_VAL;
            default: rd_val = 8'h00;
        endcase
        if (widx == IDX_LSR && acr_ff[ACR_IDXRD])
        begin
            case (sel_ff)
                IDX_ACR: rd_val = acr_ff;
                IDX_CKS: rd_val = cks_ff;
                IDX_TTL: rd_val = ttl_ff;
                IDX_RTL: rd_val = rtl_ff;
                IDX_FCL: rd_val = fcl_ff;
                IDX_FCH: rd_val = fch_ff;
                IDX_ID1: rd_val = ID1_VAL;
                IDX_ID2: rd_val = ID2_VAL;
                IDX_ID3: rd_val = ID3_VAL;
                IDX_REV: rd_val = REV_VAL;
                default: rd_val = 8'h00;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (clk_en && psel && !penable && !pwrite)
        begin
            prdata <= {24'h000000, rd_val};
        end
    end

    assign pslverr = 1'b0;

    always_comb
    begin
        ctrl_o.rx_store_en   = ~rxdis_ff;
        ctrl_o.rx_special_en = ~rxdis_ff;
        ctrl_o.tx_data_en    = ~txdis_ff
                             & ~(acr_ff[ACR_DSRFC] & dsr_n);
        ctrl_o.send_xoff     = fc_ff == FC_SEND_XOFF;
        ctrl_o.send_xon      = fc_ff == FC_SEND_XON;
        ctrl_o.rx_clk_src    = cks_ff[1:0];
        ctrl_o.rx_iso        = cks_ff[3];
        ctrl_o.tx_clk_ext    = cks_ff[6];
        ctrl_o.tx_iso        = cks_ff[7];
        ctrl_o.irq_tx        = ier_ff[IER_TX] & ((tx_th == 8'h00)
            ? (tx_idle & core_i.serial_output_idle) : (tx_cnt_ff < tx_th));
        ctrl_o.irq_rx        = ier_ff[IER_RX] & (rx_cnt_ff >= rx_th);
    end

    // Sanity checks on the outputs against their causes.
    tx_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable && !pwrite && hits_status(widx, acr_ff[ACR_ASREN])
        |=> prdata[7] == $past(core_i.tx_fifo_empty && core_i.tx_shift_empty))
        else $error("idle bit wrong");
    spec_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && core_i.rx_frame_done && core_i.rx_is_special && !rxdis_ff |=> spec_ff)
        else $error("special flag not set");
    dsr_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        acr_ff[ACR_DSRFC] && dsr_n |-> !ctrl_o.tx_data_en)
        else $error("dsr did not block");
    xoff_once_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_o.send_xoff && clk_en |=> !ctrl_o.send_xoff)
        else $error("xoff repeated");
    rts_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        efr_ff[EFR_RTS] && oob_stop_ff |-> rts_n)
        else $error("rts not deasserted");
    clk_dtr_a: assert property (@(posedge pclk) disable iff (!presetn)
        cks_ff[4] |-> dtr_n == tx_clk_1x)
        else $error("dtr clock missing");
    rx_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        acr_ff[ACR_ENH] && ier_ff[IER_RX] && rx_cnt_ff >= {1'b0, rtl_ff[6:0]} |-> ctrl_o.irq_rx)
        else $error("rx irq missing");
    cks_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        swrst_ff && clk_en && !(wr_en && widx == IDX_CKS) |=> $stable(cks_ff))
        else $error("clock select lost");
endmodule
`default_nettype wire

// [dv/uecs_core_model.sv]
// UART core model that sits behind the control block: FIFO events and status.
// Assumes bench requests are levels driven just after pclk edges.
`timescale 1ns/1ps
`default_nettype none
module uecs_core_model (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Bench requests
    input  wire logic                rx_req,
    input  wire logic                rx_spec,
    input  wire logic                rx_take,
    input  wire logic                tx_req,
    // Block side
    input  wire uecs_pkg::uecs_ctrl_t ctrl,
    output uecs_pkg::uecs_core_t      core
);
    import uecs_pkg::*;
    logic [7:0] tx_cnt_ff;
    logic       pop;
    // Data leaves only while the block allows it.
    assign pop = ctrl.tx_data_en && tx_cnt_ff != 8'h00;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_cnt_ff <= 8'h00;
        else
            tx_cnt_ff <= tx_cnt_ff + {7'h00, tx_req} - {7'h00, pop};
    end
    // The shifter is taken as instant, so idle follows the FIFO alone.
    always_comb
    begin
        core = '0;
        core.tx_fifo_empty = tx_cnt_ff == 8'h00;
        core.tx_shift_empty = 1'b1;
        core.serial_output_idle = 1'b1;
        core.tx_push = tx_req;
        core.tx_pop = pop;
        core.rx_frame_done = rx_req;
        core.rx_is_special = rx_spec;
        core.rx_pop = rx_take;
        core.line_stat_reg = {1'b0, core.tx_fifo_empty, 6'h00};
    end
endmodule
`default_nettype wire

// [dv/uecs_top_tb.sv]
// Self-checking bench for the UART enhanced control and status block.
// Assumes the core model in its own file and APB with pready answered by the block.
`timescale 1ns/1ps
`default_nettype none
module uecs_top_tb;
    import uecs_pkg::*;
    logic       pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, rd, v;
    logic [31:0] pwdata = 0, prdata;
    logic       pready, rts_n, dtr_n, fsp = 0, dsr_n = 0, tx1x = 0, baud = 0;
    logic       rx_req = 0, rx_spec = 0, rx_take = 0, tx_req = 0, ce = 1;
    uecs_core_t core;
    uecs_ctrl_t ctrl;
    int         fail_count = 0, checked = 0;
    logic [7:0] ids [4] = '{ID1_VAL, ID2_VAL, ID3_VAL, REV_VAL};
    always #25 pclk = ~pclk;
    uecs_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(), .prdata(prdata), .core_i(core), .ctrl_o(ctrl),
        .fifo_size_pin(fsp), .dsr_n(dsr_n), .tx_clk_1x(tx1x),
        .baud_gen_output(baud), .rts_n(rts_n), .dtr_n(dtr_n));
    uecs_core_model u_core (.pclk(pclk), .presetn(presetn), .rx_req(rx_req),
        .rx_spec(rx_spec), .rx_take(rx_take), .tx_req(tx_req), .ctrl(ctrl), .core(core));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        @(negedge pclk);
        checked++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count++;
        end
    endtask
    task apb(input logic w, input logic [4:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    // Pulses one core event: 0 transmit push, 1 receive frame, 2 receive pop.
    task pulse(input int k, input int n);
        @(posedge pclk);
        {rx_take, rx_req, tx_req} <= 3'(1 << k);
        repeat (n) @(posedge pclk);
        {rx_spec, rx_take, rx_req, tx_req} <= 4'h0;
        @(negedge pclk);
    endtask
    task give_verdict;
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        give_verdict;
    end
    initial
    begin
        void'($urandom(65));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, IDX_CKS, 0); chk(rd, 0);
        apb(1, IDX_ID1, 8'h5A);
        apb(1, IDX_ACR, 8'h40);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, IDX_SEL, 8'h08 + 8'(i));
            apb(0, IDX_LSR, 0); chk(rd, ids[i]);
        end
        for (int i = 0; i < 6; i++)
        begin
            v = 8'($urandom);
            v[5:4] = 2'(i % 3);
            @(posedge pclk);
            tx1x <= 1'($urandom);
            baud <= 1'($urandom);
            apb(1, IDX_CKS, v);
            chk(ctrl.rx_clk_src, v[1:0]);
            chk({ctrl.rx_iso, ctrl.tx_clk_ext, ctrl.tx_iso}, {v[3], v[6], v[7]});
            chk(dtr_n, v[5:4] == 2'b01 ? tx1x : v[5:4] == 2'b10 ? baud : 1'b1);
        end
        // Soft reset must leave the clock choice alone so the channel restarts cleanly.
        apb(1, IDX_CTL, 8'h01);
        apb(0, IDX_CKS, 0); chk(rd, v);
        apb(1, IDX_CKS, 8'h00);
        @(posedge pclk);
        fsp <= 1'($urandom);
        apb(1, IDX_MCR, 8'h02);
        apb(1, IDX_FCR, 8'h01);
        apb(1, IDX_ACR, 8'h82);
        apb(0, IDX_IER, 0); chk(rd, {2'b11, fsp, 5'b00100});
        chk({rts_n, dtr_n}, 2'b01);
        pulse(0, 1);
        apb(0, IDX_IER, 0); chk(rd[7], 1'b0);
        apb(0, IDX_LCR, 0); chk(rd, 1);
        chk(ctrl.tx_data_en, 1'b0);
        @(posedge pclk);
        dsr_n <= 1'b1;
        apb(1, IDX_ACR, 8'h94);
        chk({ctrl.tx_data_en, dtr_n}, 2'b00);
        apb(1, IDX_ACR, 8'h9C); chk(dtr_n, 1'b1);
        @(posedge pclk);
        dsr_n <= 1'b0;
        repeat (3) @(negedge pclk);
        chk(dtr_n, 1'b0);
        @(posedge pclk);
        rx_spec <= 1'b1;
        pulse(1, 1);
        apb(0, IDX_IER, 0); chk(rd[4], 1'b1);
        apb(0, IDX_IER, 0); chk(rd[4], 1'b0);
        apb(1, IDX_ACR, 8'h81);
        // The disable is taken between frames, one cycle after the write.
        @(negedge pclk);
        chk({ctrl.rx_store_en, ctrl.rx_special_en}, 2'b00);
        pulse(1, 1);
        apb(0, IDX_MCR, 0); chk(rd, 1);
        pulse(2, 1);
        apb(1, IDX_RTL, 8'h03);
        apb(1, IDX_FCL, 8'h02);
        apb(1, IDX_FCH, 8'h04);
        apb(1, IDX_TTL, 8'h02);
        apb(1, IDX_IER, 8'h03);
        apb(1, IDX_EFR, 8'h42);
        apb(1, IDX_MCR, 8'h03);
        apb(1, IDX_ACR, 8'hAA);
        chk({ctrl.irq_tx, dtr_n}, 2'b10);
        pulse(0, 2); chk(ctrl.irq_tx, 1'b0);
        apb(1, IDX_TTL, 8'h00); chk(ctrl.irq_tx, 1'b0);
        apb(1, IDX_ACR, 8'hA8);
        repeat (4) @(negedge pclk);
        chk(ctrl.irq_tx, 1'b1);
        pulse(1, 2); chk(ctrl.irq_rx, 1'b0);
        pulse(1, 1); chk({ctrl.irq_rx, rts_n}, 2'b10);
        // The stop state is registered from the count, so it lags the received frame by a cycle.
        pulse(1, 1);
        @(negedge pclk);
        chk({rts_n, dtr_n}, 2'b11);
        apb(1, IDX_MCR, 8'h13);
        apb(0, IDX_IER, 0); chk(rd[3:1], 3'b111);
        apb(1, IDX_MCR, 8'h03);
        pulse(2, 2); chk({rts_n, dtr_n}, 2'b11);
        pulse(2, 1);
        @(negedge pclk);
        chk({rts_n, dtr_n}, 2'b00);
        apb(1, IDX_ACR, 8'h88);
        pulse(1, 3); chk(rts_n, 1'b0);
        // A write while the clock enable is low must leave the register untouched.
        @(posedge pclk);
        ce <= 1'b0;
        apb(1, IDX_TTL, 8'h55);
        @(posedge pclk);
        ce <= 1'b1;
        apb(0, IDX_TTL, 0); chk(rd, 0);
        give_verdict;
    end
endmodule
`default_nettype wire
